/* chb_channel_b.sv */
// Second memory channel pin interface: command, address, data, mask and strobes
// Contract
// [R01] 64-bit read and write data moves over a 64-line two-way data bus.
// [R02] One byte mask per lane; a set mask leaves that SDRAM byte unchanged.
// [R03] Byte masks give partial writes updating only the selected bytes.
// [R04] Write bursts are cut short by masking all remaining beats.
// [R05] DDR: data captured on both edges of the eight single-ended strobes.
// [R06] DDR2: strobes pair with complements; data taken at their crossing.
// [R07] Complement strobes stay unused and undriven with DDR memory.
// [R08] Row then column address share the 14-bit address bus in time.
// [R09] Address bit 13 is driven only for 1 Gb devices.
// [R10] A three-bit bank select picks the bank within the selected rank.
// [R11] Top bank bit used only with DDR2; DDR uses two bits.
// [R12] Commands combine row strobe, column strobe, write enable and rank select.
// [R13] Single-channel mode leaves data, mask and strobe lines unused.
// [R14] Single-channel mode: address, bank and command lines serve the second slot.
// [R15] Dual-channel mode: a complete independent channel with all lines.
// [R16] Receive-enable out/in pair times read data sampling.
// [R17] Four active-low rank selects, one per rank, pick command targets.
// [R18] Commands follow the standard SDRAM truth table.
`timescale 1ns/100ps
`default_nettype none

module chb_channel_b (
  input wire logic CLOCK,
  input wire logic NRST,
  input wire logic MCLK,
  input wire logic CFG_DDR2,
  input wire logic CFG_DUAL,
  input wire logic CFG_BIG_DEV,
  input wire logic REQ_VALID,
  output logic REQ_READY,
  input wire chb_pkg::chb_req_t REQ,
  output logic RD_VALID,
  output logic [chb_pkg::DATA_W-1:0] RD_DATA,
  input wire logic [chb_pkg::DATA_W-1:0] DATA_IN,
  output logic [chb_pkg::DATA_W-1:0] DATA_OUT,
  output logic DATA_OE_N,
  input wire logic [chb_pkg::MASK_W-1:0] STROBE_IN,
  output logic [chb_pkg::MASK_W-1:0] STROBE_OUT,
  output logic STROBE_OE_N,
  input wire logic [chb_pkg::MASK_W-1:0] STROBE_C_IN,
  output logic [chb_pkg::MASK_W-1:0] STROBE_C_OUT,
  output logic STROBE_C_OE_N,
  output logic [chb_pkg::MASK_W-1:0] BYTE_MASK,
  output logic [chb_pkg::ADDR_W-1:0] MEM_ADDRESS,
  output logic [chb_pkg::BANK_W-1:0] BANK_SELECT,
  output logic ROW_STROBE_N,
  output logic COL_STROBE_N,
  output logic WRITE_ENABLE_N,
  output logic [chb_pkg::RANK_W-1:0] RANK_SELECT_N,
  output logic RECV_ENABLE_OUT_N,
  input wire logic RECV_ENABLE_IN_N
);

  // ----------------------------------------------------------------------------
  // Core side: request hold and toggle handshake
  // ----------------------------------------------------------------------------
  chb_pkg::chb_req_t hold_r, hold_nxt;
  logic pend_r, pend_nxt;
  logic ready_r, ready_nxt;
  logic req_tgl_r, req_tgl_nxt;
  logic ack_s1_r, ack_s2_r, ack_s3_r;
  logic rdt_s1_r, rdt_s2_r, rdt_s3_r;
  logic rd_valid_r, rd_valid_nxt;
  logic [chb_pkg::DATA_W-1:0] rd_data_r, rd_data_nxt;
  logic ack_tgl_r;
  logic rd_tgl_r;
  logic [chb_pkg::DATA_W-1:0] rd_word_r;

  always_comb begin
    hold_nxt = hold_r;
    pend_nxt = pend_r;
    req_tgl_nxt = req_tgl_r;
    rd_valid_nxt = rdt_s2_r ^ rdt_s3_r;
    rd_data_nxt = rd_data_r;
    // Read word in the link domain is stable once its toggle arrives here
    if (rdt_s2_r ^ rdt_s3_r) begin
      rd_data_nxt = rd_word_r;
    end
    if (ack_s2_r ^ ack_s3_r) begin
      pend_nxt = 1'b0;
    end
    if (ready_r && REQ_VALID) begin
      hold_nxt = REQ;
      pend_nxt = 1'b1;
      req_tgl_nxt = ~req_tgl_r;
    end
    ready_nxt = ~pend_nxt;
  end

  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      hold_r <= '0;
      pend_r <= 1'b0;
      ready_r <= 1'b0;
      req_tgl_r <= 1'b0;
      ack_s1_r <= 1'b0;
      ack_s2_r <= 1'b0;
      ack_s3_r <= 1'b0;
      rdt_s1_r <= 1'b0;
      rdt_s2_r <= 1'b0;
      rdt_s3_r <= 1'b0;
      rd_valid_r <= 1'b0;
      rd_data_r <= '0;
    end else begin
      hold_r <= hold_nxt;
      pend_r <= pend_nxt;
      ready_r <= ready_nxt;
      req_tgl_r <= req_tgl_nxt;
      ack_s1_r <= ack_tgl_r;
      ack_s2_r <= ack_s1_r;
      ack_s3_r <= ack_s2_r;
      rdt_s1_r <= rd_tgl_r;
      rdt_s2_r <= rdt_s1_r;
      rdt_s3_r <= rdt_s2_r;
      rd_valid_r <= rd_valid_nxt;
      rd_data_r <= rd_data_nxt;
    end
  end

  assign REQ_READY = ready_r;
  assign RD_VALID = rd_valid_r;
  assign RD_DATA = rd_data_r;

  // ----------------------------------------------------------------------------
  // Link side: synchronisers
  // ----------------------------------------------------------------------------
  logic lrst_s1_r, lrst_n;
  logic req_s1_r, req_s2_r, req_s3_r;
  chb_pkg::chb_cfg_t cfg_s1_r, cfg_r;
  logic [chb_pkg::DATA_W-1:0] dq_s1_r, dq_s2_r;
  logic [chb_pkg::MASK_W-1:0] dqs_s1_r, dqs_s2_r, dqs_s3_r;
  logic [chb_pkg::MASK_W-1:0] dqsc_s1_r, dqsc_s2_r;
  logic rcv_s1_r, rcv_s2_r;

  always_ff @(posedge MCLK) begin
    lrst_s1_r <= NRST;
    lrst_n <= lrst_s1_r;
  end

  always_ff @(posedge MCLK) begin
    if (!lrst_n) begin
      req_s1_r <= 1'b0;
      req_s2_r <= 1'b0;
      req_s3_r <= 1'b0;
      cfg_s1_r <= '0;
      cfg_r <= '0;
      dq_s1_r <= '0;
      dq_s2_r <= '0;
      dqs_s1_r <= '0;
      dqs_s2_r <= '0;
      dqs_s3_r <= '0;
      dqsc_s1_r <= '0;
      dqsc_s2_r <= '0;
      rcv_s1_r <= 1'b1;
      rcv_s2_r <= 1'b1;
    end else begin
      req_s1_r <= req_tgl_r;
      req_s2_r <= req_s1_r;
      req_s3_r <= req_s2_r;
      cfg_s1_r <= {CFG_DDR2, CFG_DUAL, CFG_BIG_DEV};
      cfg_r <= cfg_s1_r;
      dq_s1_r <= DATA_IN;
      dq_s2_r <= dq_s1_r;
      dqs_s1_r <= STROBE_IN;
      dqs_s2_r <= dqs_s1_r;
      dqs_s3_r <= dqs_s2_r;
      dqsc_s1_r <= STROBE_C_IN;
      dqsc_s2_r <= dqsc_s1_r;
      rcv_s1_r <= RECV_ENABLE_IN_N;
      rcv_s2_r <= rcv_s1_r;
    end
  end

  // ----------------------------------------------------------------------------
  // Link side: command and burst sequencer
  // ----------------------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_CMD = 5'b00010,
    ST_WAIT = 5'b00100,
    ST_BURST = 5'b01000,
    ST_DONE = 5'b10000
  } chb_state_t;

  chb_state_t st_r, st_nxt;
  chb_pkg::chb_pins_t enc_pins;
  chb_pkg::chb_pins_t pins_r, pins_nxt;
  logic [chb_pkg::LAT_W-1:0] lat_r, lat_nxt;
  logic [chb_pkg::BEAT_W-1:0] beat_r, beat_nxt;
  logic [chb_pkg::ADDR_W-1:0] ma_r, ma_nxt;
  logic [chb_pkg::BANK_W-1:0] bs_r, bs_nxt;
  logic [chb_pkg::RANK_W-1:0] cs_r, cs_nxt;
  logic [chb_pkg::DATA_W-1:0] dq_r, dq_nxt;
  logic dq_oe_r, dq_oe_nxt;
  logic [chb_pkg::MASK_W-1:0] dqs_r, dqs_nxt;
  logic dqs_oe_r, dqs_oe_nxt;
  logic dqsc_oe_r, dqsc_oe_nxt;
  logic [chb_pkg::MASK_W-1:0] dm_r, dm_nxt;
  logic rcv_out_r, rcv_out_nxt;
  logic ack_tgl_nxt, rd_tgl_nxt;
  logic [chb_pkg::DATA_W-1:0] rd_word_nxt;
  logic got_r, got_nxt;
  logic is_rd, is_wr, data_on, strobe_ok;

  chb_cmd_encoder u_enc (
    .cmd(hold_r.cmd),
    .pins(enc_pins)
  );

  assign is_rd = (hold_r.cmd == chb_pkg::CMD_READ);
  assign is_wr = (hold_r.cmd == chb_pkg::CMD_WRITE);
  // Data, mask and strobes only take part in dual-channel mode
  assign data_on = cfg_r.dual; // [R13] [R15]
  // DDR samples on any strobe edge; DDR2 also needs a true differential pair
  assign strobe_ok = (dqs_s2_r != dqs_s3_r) && (!cfg_r.ddr2 || (dqs_s2_r == ~dqsc_s2_r)); // [R05] [R06]

  always_comb begin
    st_nxt = st_r;
    pins_nxt = 3'b111;
    lat_nxt = lat_r;
    beat_nxt = beat_r;
    ma_nxt = ma_r;
    bs_nxt = bs_r;
    cs_nxt = chb_pkg::RANK_IDLE_N;
    dq_nxt = dq_r;
    dq_oe_nxt = 1'b0;
    dqs_nxt = chb_pkg::MASK_NONE;
    dqs_oe_nxt = 1'b0;
    dqsc_oe_nxt = 1'b0;
    dm_nxt = chb_pkg::MASK_NONE;
    rcv_out_nxt = 1'b1;
    ack_tgl_nxt = ack_tgl_r;
    rd_tgl_nxt = rd_tgl_r;
    rd_word_nxt = rd_word_r;
    got_nxt = got_r;
    unique case (st_r)
      ST_IDLE: begin
        if (req_s2_r ^ req_s3_r) begin
          st_nxt = ST_CMD;
        end
      end
      ST_CMD: begin
        // Row address goes with activate, column address with read/write
        ma_nxt = hold_r.addr; // [R08] [R14]
        ma_nxt[chb_pkg::ADDR_TOP_BIT] = hold_r.addr[chb_pkg::ADDR_TOP_BIT] & cfg_r.big_dev; // [R09]
        bs_nxt = hold_r.bank; // [R10]
        bs_nxt[chb_pkg::BANK_TOP_BIT] = hold_r.bank[chb_pkg::BANK_TOP_BIT] & cfg_r.ddr2; // [R11]
        pins_nxt = enc_pins; // [R12] [R18]
        cs_nxt = ~(4'h1 << hold_r.rank); // [R17] [R12]
        got_nxt = 1'b0;
        if ((is_rd || is_wr) && data_on) begin
          lat_nxt = is_rd ? chb_pkg::RD_LATENCY : chb_pkg::WR_LATENCY;
          st_nxt = ST_WAIT;
        end else begin
          st_nxt = ST_DONE;
        end
      end
      ST_WAIT: begin
        lat_nxt = lat_r - 4'h1;
        // Receive enable opens the read sampling window one cycle early
        rcv_out_nxt = ~(is_rd && (lat_r == 4'h1)); // [R16]
        if (is_wr && (lat_r == 4'h1)) begin
          dqs_oe_nxt = 1'b1;
          dqsc_oe_nxt = cfg_r.ddr2; // [R07]
        end
        if (lat_r == 4'h1) begin
          beat_nxt = '0;
          st_nxt = ST_BURST;
        end
      end
      ST_BURST: begin
        beat_nxt = beat_r + 3'h1;
        if (is_wr) begin
          dq_nxt = hold_r.wdata; // [R01]
          dq_oe_nxt = 1'b1; // [R01]
          dqs_oe_nxt = 1'b1; // [R05]
          dqsc_oe_nxt = cfg_r.ddr2; // [R06] [R07]
          dqs_nxt = beat_r[0] ? chb_pkg::MASK_NONE : chb_pkg::MASK_ALL; // [R05] [R06]
          // Beats past the kept count are fully masked, ending the burst early
          dm_nxt = (beat_r >= hold_r.keep_beats) ? chb_pkg::MASK_ALL : hold_r.byte_mask; // [R02] [R03] [R04]
        end else begin
          rcv_out_nxt = 1'b0; // [R16]
          if (!rcv_s2_r && strobe_ok && !got_r) begin
            rd_word_nxt = dq_s2_r; // [R01] [R16]
            got_nxt = 1'b1;
          end
        end
        if (beat_r == chb_pkg::BURST_BEATS - 3'h1) begin
          st_nxt = ST_DONE;
        end
      end
      ST_DONE: begin
        // A dual-channel read that never saw its window still answers, with the last word
        if (is_rd && data_on) begin
          rd_tgl_nxt = ~rd_tgl_r;
        end
        ack_tgl_nxt = ~ack_tgl_r;
        st_nxt = ST_IDLE;
      end
      default: st_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge MCLK) begin
    if (!lrst_n) begin
      st_r <= ST_IDLE;
      pins_r <= 3'b111;
      lat_r <= '0;
      beat_r <= '0;
      ma_r <= '0;
      bs_r <= '0;
      cs_r <= chb_pkg::RANK_IDLE_N;
      dq_r <= '0;
      dq_oe_r <= 1'b0;
      dqs_r <= chb_pkg::MASK_NONE;
      dqs_oe_r <= 1'b0;
      dqsc_oe_r <= 1'b0;
      dm_r <= chb_pkg::MASK_NONE;
      rcv_out_r <= 1'b1;
      ack_tgl_r <= 1'b0;
      rd_tgl_r <= 1'b0;
      rd_word_r <= '0;
      got_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      pins_r <= pins_nxt;
      lat_r <= lat_nxt;
      beat_r <= beat_nxt;
      ma_r <= ma_nxt;
      bs_r <= bs_nxt;
      cs_r <= cs_nxt;
      dq_r <= dq_nxt;
      dq_oe_r <= dq_oe_nxt;
      dqs_r <= dqs_nxt;
      dqs_oe_r <= dqs_oe_nxt;
      dqsc_oe_r <= dqsc_oe_nxt;
      dm_r <= dm_nxt;
      rcv_out_r <= rcv_out_nxt;
      ack_tgl_r <= ack_tgl_nxt;
      rd_tgl_r <= rd_tgl_nxt;
      rd_word_r <= rd_word_nxt;
      got_r <= got_nxt;
    end
  end

  // ----------------------------------------------------------------------------
  // Pin outputs, all from link-domain flops
  // ----------------------------------------------------------------------------
  assign DATA_OUT = dq_r;
  assign DATA_OE_N = ~dq_oe_r;
  assign STROBE_OUT = dqs_r;
  assign STROBE_OE_N = ~dqs_oe_r;
  assign STROBE_C_OUT = ~dqs_r;
  assign STROBE_C_OE_N = ~dqsc_oe_r;
  assign BYTE_MASK = dm_r;
  assign MEM_ADDRESS = ma_r;
  assign BANK_SELECT = bs_r;
  assign ROW_STROBE_N = pins_r.row_strobe_n;
  assign COL_STROBE_N = pins_r.col_strobe_n;
  assign WRITE_ENABLE_N = pins_r.write_enable_n;
  assign RANK_SELECT_N = cs_r;
  assign RECV_ENABLE_OUT_N = rcv_out_r;

endmodule // chb_channel_b

`default_nettype wire

/* chb_pkg.sv */
// Package and command encoder for the second-channel DDR/DDR2 pin interface
`timescale 1ns/100ps
`default_nettype none

package chb_pkg;
  localparam int DATA_W = 64;
  localparam int MASK_W = 8;
  localparam int ADDR_W = 14;
  localparam int BANK_W = 3;
  localparam int RANK_W = 4;
  localparam int RSEL_W = 2;
  localparam int BEAT_W = 3;
  localparam int LAT_W = 4;
  // Address bit only needed by 1 Gb parts; bank bit only by DDR2
  localparam int ADDR_TOP_BIT = 13;
  localparam int BANK_TOP_BIT = 2;
  localparam logic [BEAT_W-1:0] BURST_BEATS = 3'h4;
  localparam logic [LAT_W-1:0] WR_LATENCY = 4'h2;
  localparam logic [LAT_W-1:0] RD_LATENCY = 4'h3;
  localparam logic [RANK_W-1:0] RANK_IDLE_N = 4'hF;
  localparam logic [MASK_W-1:0] MASK_ALL = 8'hFF;
  localparam logic [MASK_W-1:0] MASK_NONE = 8'h00;

  typedef enum logic [2:0] {
    CMD_NOP = 3'h0,
    CMD_ACT = 3'h1,
    CMD_READ = 3'h2,
    CMD_WRITE = 3'h3,
    CMD_PRE = 3'h4,
    CMD_REF = 3'h5,
    CMD_MRS = 3'h6
  } chb_cmd_t;

  typedef struct packed {
    chb_cmd_t cmd;
    logic [RSEL_W-1:0] rank;
    logic [BANK_W-1:0] bank;
    logic [ADDR_W-1:0] addr;
    logic [BEAT_W-1:0] keep_beats;
    logic [MASK_W-1:0] byte_mask;
    logic [DATA_W-1:0] wdata;
  } chb_req_t;

  typedef struct packed {
    logic row_strobe_n;
    logic col_strobe_n;
    logic write_enable_n;
  } chb_pins_t;

  typedef struct packed {
    logic ddr2;
    logic dual;
    logic big_dev;
  } chb_cfg_t;
endpackage

// ----------------------------------------------------------------------------
// Command encoder
// ----------------------------------------------------------------------------
module chb_cmd_encoder (
  input wire chb_pkg::chb_cmd_t cmd,
  output chb_pkg::chb_pins_t pins
);
  always_comb begin
    unique case (cmd)
      chb_pkg::CMD_ACT: pins = 3'b011; // [R18]
      chb_pkg::CMD_READ: pins = 3'b101; // [R18]
      chb_pkg::CMD_WRITE: pins = 3'b100; // [R18]
      chb_pkg::CMD_PRE: pins = 3'b010; // [R18]
      chb_pkg::CMD_REF: pins = 3'b001; // [R18]
      chb_pkg::CMD_MRS: pins = 3'b000; // [R18]
      default: pins = 3'b111;
    endcase
  end
endmodule // chb_cmd_encoder

`default_nettype wire

/* chb_channel_b_props.sv */
// Concurrent checks on the second-channel pin interface
`timescale 1ns/100ps
`default_nettype none
module chb_channel_b_props (
  input wire logic CLOCK,
  input wire logic NRST,
  input wire logic MCLK,
  input wire logic CFG_DDR2,
  input wire logic CFG_DUAL,
  input wire logic CFG_BIG_DEV,
  input wire logic REQ_VALID,
  input wire logic REQ_READY,
  input wire logic RD_VALID,
  input wire logic DATA_OE_N,
  input wire logic [7:0] STROBE_OUT,
  input wire logic STROBE_OE_N,
  input wire logic [7:0] STROBE_C_OUT,
  input wire logic STROBE_C_OE_N,
  input wire logic [13:0] MEM_ADDRESS,
  input wire logic [2:0] BANK_SELECT,
  input wire logic ROW_STROBE_N,
  input wire logic COL_STROBE_N,
  input wire logic WRITE_ENABLE_N,
  input wire logic [3:0] RANK_SELECT_N,
  input wire logic RECV_ENABLE_OUT_N
);
  // ------
  // Link side
  // ------
  wire cmd_on = (RANK_SELECT_N != 4'hF);
  wire [2:0] pins = {ROW_STROBE_N, COL_STROBE_N, WRITE_ENABLE_N};
  a_rank_onehot: assert property (@(posedge MCLK) disable iff (!NRST)
    cmd_on |-> $onehot(~RANK_SELECT_N) ##1 !cmd_on) else $error("rank select not one-hot for one cycle");
  a_pins_need_rank: assert property (@(posedge MCLK) disable iff (!NRST)
    pins != 3'h7 |-> cmd_on) else $error("command pins without rank select");
  a_addr_top_bit: assert property (@(posedge MCLK) disable iff (!NRST)
    !CFG_BIG_DEV |-> !MEM_ADDRESS[13]) else $error("address bit 13 driven for small parts");
  a_bank_top_bit: assert property (@(posedge MCLK) disable iff (!NRST)
    !CFG_DDR2 |-> !BANK_SELECT[2]) else $error("bank bit 2 driven with DDR");
  a_comp_idle: assert property (@(posedge MCLK) disable iff (!NRST)
    !CFG_DDR2 |-> STROBE_C_OE_N) else $error("complement strobes driven with DDR");
  a_single_quiet: assert property (@(posedge MCLK) disable iff (!NRST)
    !CFG_DUAL |-> DATA_OE_N && STROBE_OE_N) else $error("data lines driven in single mode");
  a_write_burst: assert property (@(posedge MCLK) disable iff (!NRST)
    cmd_on && pins == 3'h4 && CFG_DUAL |-> DATA_OE_N [*3] ##1 !DATA_OE_N [*4] ##1 DATA_OE_N)
    else $error("write burst timing");
  a_comp_invert: assert property (@(posedge MCLK) disable iff (!NRST)
    !STROBE_C_OE_N |-> STROBE_C_OUT == ~STROBE_OUT && !STROBE_OE_N) else $error("complement strobe");
  a_recv_window: assert property (@(posedge MCLK) disable iff (!NRST)
    cmd_on && pins == 3'h5 && CFG_DUAL |-> RECV_ENABLE_OUT_N [*3] ##1 !RECV_ENABLE_OUT_N [*5]
    ##1 RECV_ENABLE_OUT_N) else $error("receive enable window");
  a_strobe_beats: assert property (@(posedge MCLK) disable iff (!NRST)
    $fell(DATA_OE_N) |-> STROBE_OUT == 8'hFF ##1 STROBE_OUT == 8'h00) else $error("strobe beat levels");
  // ------
  // Core side, with the link-side write and read covers
  // ------
  a_ready_drop: assert property (@(posedge CLOCK) disable iff (!NRST)
    REQ_VALID && REQ_READY |=> !REQ_READY [*4]) else $error("ready did not drop");
  a_rd_pulse: assert property (@(posedge CLOCK) disable iff (!NRST)
    RD_VALID |-> CFG_DUAL ##1 !RD_VALID) else $error("read valid pulse");
  c_write: cover property (@(posedge MCLK) disable iff (!NRST) cmd_on && pins == 3'h4 && CFG_DUAL);
  c_read: cover property (@(posedge MCLK) disable iff (!NRST) cmd_on && pins == 3'h5 && CFG_DUAL);
  c_rdata: cover property (@(posedge CLOCK) disable iff (!NRST) RD_VALID);
endmodule // chb_channel_b_props

bind chb_channel_b chb_channel_b_props u_props (.CLOCK, .NRST, .MCLK, .CFG_DDR2, .CFG_DUAL, .CFG_BIG_DEV,
  .REQ_VALID, .REQ_READY, .RD_VALID, .DATA_OE_N, .STROBE_OUT, .STROBE_OE_N, .STROBE_C_OUT, .STROBE_C_OE_N,
  .MEM_ADDRESS, .BANK_SELECT, .ROW_STROBE_N, .COL_STROBE_N, .WRITE_ENABLE_N, .RANK_SELECT_N,
  .RECV_ENABLE_OUT_N);
`default_nettype wire

/* chb_sdram_model.sv */
// Behavioural SDRAM module on the second channel
`timescale 1ns/100ps
`default_nettype none
module chb_sdram_model (
  input wire logic clk,
  input wire logic ddr2,
  input wire logic [63:0] dq_o,
  input wire logic dq_oe_n,
  input wire logic [7:0] dqs_o,
  input wire logic [7:0] dqs_co,
  input wire logic [7:0] dm,
  input wire logic [13:0] addr,
  input wire logic [2:0] bank,
  input wire logic [2:0] pins,
  input wire logic [3:0] cs_n,
  input wire logic rcv_o_n,
  output logic [63:0] dq_i,
  output logic [7:0] dqs_i,
  output logic [7:0] dqs_ci,
  output logic rcv_i_n,
  output chb_pkg::chb_cmd_t cmd,
  output logic [1:0] rank,
  output logic [13:0] addr_s,
  output logic [2:0] bank_s,
  output logic [7:0] mask_s,
  output int beats,
  output int serr
);
  logic [63:0] mem [8];
  int rd_t;
  int bidx;
  initial begin
    foreach (mem[i]) mem[i] = 64'h0;
    {dq_i, dqs_i, dqs_ci, rcv_i_n, rank, addr_s, bank_s, mask_s} = '0;
    cmd = chb_pkg::CMD_NOP;
    {rd_t, bidx, beats, serr} = '0;
  end
  // Released lines toggle every cycle so a stale value can never look valid
  always @(posedge clk) begin
    rd_t <= rd_t + 1;
    rcv_i_n <= rcv_o_n;
    dqs_i <= ~dqs_i;
    dqs_ci <= ddr2 ? dqs_i : ~dqs_ci;
    dq_i <= (rd_t >= 2 && rd_t <= 12) ? mem[bank_s] : ~dq_i;
    if (cs_n != 4'hF) begin
      for (int i = 0; i < 4; i++) if (!cs_n[i]) rank <= 2'(i);
      case (pins)
        3'h3: cmd <= chb_pkg::CMD_ACT;
        3'h5: cmd <= chb_pkg::CMD_READ;
        3'h4: cmd <= chb_pkg::CMD_WRITE;
        3'h2: cmd <= chb_pkg::CMD_PRE;
        3'h1: cmd <= chb_pkg::CMD_REF;
        3'h0: cmd <= chb_pkg::CMD_MRS;
        default: cmd <= chb_pkg::CMD_NOP;
      endcase
      addr_s <= addr;
      bank_s <= bank;
      rd_t <= 0;
      bidx <= 0;
      beats <= 0;
    end
    if (!dq_oe_n) begin
      bidx <= bidx + 1;
      if (bidx == 0) mask_s <= dm;
      if (dm != 8'hFF) beats <= beats + 1;
      for (int i = 0; i < 8; i++) if (!dm[i]) mem[bank_s][8*i+:8] <= dq_o[8*i+:8];
      if (dqs_o !== (bidx[0] ? 8'h00 : 8'hFF) || (ddr2 && dqs_co !== ~dqs_o)) serr <= serr + 1;
    end
  end
endmodule // chb_sdram_model
`default_nettype wire

/* chb_channel_b_bench.sv */
// Self-checking bench of the second-channel pin interface
`timescale 1ns/100ps
`default_nettype none
module chb_channel_b_bench;
  logic CLOCK, NRST, MCLK, CFG_DDR2, CFG_DUAL, CFG_BIG_DEV, REQ_VALID, REQ_READY, RD_VALID;
  logic DATA_OE_N, STROBE_OE_N, STROBE_C_OE_N, ROW_STROBE_N, COL_STROBE_N, WRITE_ENABLE_N;
  logic RECV_ENABLE_OUT_N, RECV_ENABLE_IN_N;
  chb_pkg::chb_req_t REQ;
  chb_pkg::chb_cmd_t m_cmd;
  logic [63:0] RD_DATA, DATA_IN, DATA_OUT, m_dq, rd_word;
  logic [7:0] STROBE_IN, STROBE_OUT, STROBE_C_IN, STROBE_C_OUT, BYTE_MASK, m_dqs, m_dqsc, m_mask;
  logic [13:0] MEM_ADDRESS, m_addr;
  logic [2:0] BANK_SELECT, m_bank;
  logic [3:0] RANK_SELECT_N;
  logic [1:0] m_rank;
  logic [63:0] exp_mem [8];
  int m_beats, m_serr, err_total, checks, rd_cnt, seed;
  // Wire level of the two-way pins
  assign DATA_IN = DATA_OE_N ? m_dq : DATA_OUT;
  assign STROBE_IN = STROBE_OE_N ? m_dqs : STROBE_OUT;
  assign STROBE_C_IN = STROBE_C_OE_N ? m_dqsc : STROBE_C_OUT;
  chb_channel_b dut (.CLOCK, .NRST, .MCLK, .CFG_DDR2, .CFG_DUAL, .CFG_BIG_DEV, .REQ_VALID, .REQ_READY, .REQ,
    .RD_VALID, .RD_DATA, .DATA_IN, .DATA_OUT, .DATA_OE_N, .STROBE_IN, .STROBE_OUT, .STROBE_OE_N, .STROBE_C_IN,
    .STROBE_C_OUT, .STROBE_C_OE_N, .BYTE_MASK, .MEM_ADDRESS, .BANK_SELECT, .ROW_STROBE_N, .COL_STROBE_N,
    .WRITE_ENABLE_N, .RANK_SELECT_N, .RECV_ENABLE_OUT_N, .RECV_ENABLE_IN_N);
  chb_sdram_model far (.clk(MCLK), .ddr2(CFG_DDR2), .dq_o(DATA_OUT), .dq_oe_n(DATA_OE_N), .dqs_o(STROBE_OUT),
    .dqs_co(STROBE_C_OUT), .dm(BYTE_MASK), .addr(MEM_ADDRESS), .bank(BANK_SELECT),
    .pins({ROW_STROBE_N, COL_STROBE_N, WRITE_ENABLE_N}), .cs_n(RANK_SELECT_N), .rcv_o_n(RECV_ENABLE_OUT_N),
    .dq_i(m_dq), .dqs_i(m_dqs), .dqs_ci(m_dqsc), .rcv_i_n(RECV_ENABLE_IN_N), .cmd(m_cmd), .rank(m_rank),
    .addr_s(m_addr), .bank_s(m_bank), .mask_s(m_mask), .beats(m_beats), .serr(m_serr));
  // ------
  // Clocks and helpers
  // ------
  initial begin
    CLOCK = 1'b0;
    forever #4 CLOCK = ~CLOCK;
  end
  initial begin
    MCLK = 1'b0;
    #1.3;
    forever #3 MCLK = ~MCLK;
  end
  always @(posedge CLOCK) if (RD_VALID === 1'b1) begin
    rd_cnt <= rd_cnt + 1;
    rd_word <= RD_DATA;
  end
  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  function automatic logic [63:0] merge(input logic [63:0] o, input logic [63:0] w, input logic [7:0] m);
    merge = o;
    for (int i = 0; i < 8; i++) if (!m[i]) merge[8*i+:8] = w[8*i+:8];
  endfunction
  task automatic restart(input logic d2, input logic du, input logic bg);
    @(posedge CLOCK);
    NRST <= 1'b0;
    CFG_DDR2 <= d2;
    CFG_DUAL <= du;
    CFG_BIG_DEV <= bg;
    repeat (5) @(posedge CLOCK);
    NRST <= 1'b1;
  endtask
  task automatic op(input chb_pkg::chb_cmd_t c, input int kb_set = -1, input int bm_set = -1);
    logic [1:0] rk;
    logic [2:0] bk, kb, be;
    logic [13:0] ad;
    logic [7:0] bm;
    logic [63:0] wd;
    int n, r0;
    rk = 2'($random(seed));
    bk = 3'($random(seed));
    kb = 3'($random(seed));
    ad = 14'($random(seed));
    bm = ($random(seed) % 3 == 0) ? 8'h00 : 8'($random(seed));
    wd = {$random(seed), $random(seed)};
    if (kb_set >= 0) kb = 3'(kb_set);
    if (bm_set >= 0) bm = 8'(bm_set);
    be = bk & (CFG_DDR2 ? 3'h7 : 3'h3);
    r0 = rd_cnt;
    n = 0;
    while (REQ_READY !== 1'b1 && n < 100) begin @(negedge CLOCK); n++; end
    @(posedge CLOCK);
    REQ_VALID <= 1'b1;
    REQ <= '{c, rk, bk, ad, kb, bm, wd};
    @(posedge CLOCK);
    REQ_VALID <= 1'b0;
    repeat (2) @(negedge CLOCK);
    n = 0;
    while (REQ_READY !== 1'b1 && n < 200) begin @(negedge CLOCK); n++; end
    repeat (10) @(negedge CLOCK);
    chk("ready", REQ_READY, 1'b1);
    chk("command", m_cmd, c);
    chk("rank", m_rank, rk);
    chk("bank", m_bank, be);
    if (c <= chb_pkg::CMD_WRITE) chk("address", m_addr, ad & (CFG_BIG_DEV ? 14'h3FFF : 14'h1FFF));
    if (c == chb_pkg::CMD_WRITE) begin
      chk("beats", m_beats, (CFG_DUAL && bm != 8'hFF) ? ((kb > 4) ? 4 : kb) : 0);
      if (CFG_DUAL) chk("mask", m_mask, (kb == 0) ? 8'hFF : bm);
      if (CFG_DUAL && kb != 0) exp_mem[be] = merge(exp_mem[be], wd, bm);
    end
    if (c == chb_pkg::CMD_READ) begin
      chk("reads", rd_cnt - r0, CFG_DUAL ? 1 : 0);
      if (CFG_DUAL) chk("read data", rd_word, exp_mem[be]);
    end
  endtask
  task give_verdict;
    if (err_total == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // ------
  // Main sequence
  // ------
  initial begin
    {NRST, REQ_VALID, err_total, checks, rd_cnt} = '0;
    {CFG_DDR2, CFG_DUAL, CFG_BIG_DEV} = 3'h2;
    REQ = '0;
    rd_word = '0;
    seed = 70;
    foreach (exp_mem[i]) exp_mem[i] = 64'h0;
    for (int k = 0; k < 3; k++) begin
      restart(k == 1, k != 2, k != 0);
      for (int r = 0; r < 3; r++) for (int i = 0; i < 7; i++) op(chb_pkg::chb_cmd_t'(i));
      // Corners: whole burst masked, every byte masked, full unmasked write, then read back
      op(chb_pkg::CMD_WRITE, 0, -1);
      op(chb_pkg::CMD_WRITE, 7, 255);
      op(chb_pkg::CMD_WRITE, 4, 0);
      op(chb_pkg::CMD_READ);
    end
    chk("strobes", m_serr, 0);
    give_verdict();
  end
  initial begin
    repeat (30000) @(posedge CLOCK);
    err_total++;
    give_verdict();
  end
endmodule // chb_channel_b_bench
`default_nettype wire
